// File: logic/regbank_pkg.sv
// Purpose: shared constants, register attribute table and carrier types
// Assumes: byte-wide register map, one clock domain
// Notes:   the attribute table lists only the registers built in this block
package regbank_pkg;

  // --------------------------------------------------------------
  // address map
  // --------------------------------------------------------------
  localparam logic [15:0] ADDR_MIN      = 16'h0000;
  localparam logic [15:0] ADDR_MAX      = 16'h1788;
  localparam logic [15:0] TRIG_ADDR     = 16'h000f;
  localparam logic [7:0]  TRIG_GO       = 8'h01;
  localparam logic [7:0]  DENIED_BYTE   = 8'h00;
  localparam int          NUM_REGS      = 13;
  localparam int          IDX_W         = 4;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [2:0]
  {
    WD_NONE                     = 3'b000,
    WD_CLASS_LOCK_RESTART       = 3'b001,
    WD_CLASS_REF_FAULT          = 3'b010,
    WD_CLASS_UNLOCK             = 3'b011,
    WD_CLASS_WATCHDOG_RESET     = 3'b100,
    WD_CLASS_STABILITY_RESET    = 3'b101,
    WD_CLASS_FUNCTION_SWAP      = 3'b110,
    WD_CLASS_DEMAP_REF_FAULT    = 3'b111
  } wd_class_type;

  typedef enum logic [1:0]
  {
    HO_IDLE   = 2'b00,
    HO_ARMED  = 2'b01,
    HO_ACTIVE = 2'b10
  } holdover_state_type;

  typedef struct packed
  {
    logic [15:0]  addr;
    logic         ro;
    logic         live;
    logic         aclr;
    logic         excl;
    wd_class_type wd;
    logic [1:0]   ref_id;
    logic [7:0]   rst;
  } reg_attr_type;

  typedef struct packed
  {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bus_req_type;

  typedef struct packed
  {
    logic       ack;
    logic       denied;
    logic [7:0] rdata;
  } bus_rsp_type;

  // --------------------------------------------------------------
  // attribute table, sorted by ascending address
  // --------------------------------------------------------------
  localparam reg_attr_type REG_TABLE [NUM_REGS] = '{
    '{16'h0003, 1'b1, 1'b0, 1'b0, 1'b1, WD_NONE,                  2'd0, 8'h05},
    '{16'h0100, 1'b0, 1'b1, 1'b0, 1'b0, WD_NONE,                  2'd0, 8'h00},
    '{16'h0101, 1'b0, 1'b1, 1'b0, 1'b1, WD_NONE,                  2'd0, 8'h00},
    '{16'h0200, 1'b0, 1'b0, 1'b0, 1'b0, WD_CLASS_LOCK_RESTART,    2'd0, 8'h00},
    '{16'h0201, 1'b0, 1'b0, 1'b0, 1'b0, WD_CLASS_LOCK_RESTART,    2'd0, 8'h00},
    '{16'h0300, 1'b0, 1'b0, 1'b0, 1'b0, WD_CLASS_REF_FAULT,       2'd0, 8'h00},
    '{16'h0301, 1'b0, 1'b0, 1'b0, 1'b0, WD_CLASS_REF_FAULT,       2'd1, 8'h00},
    '{16'h0400, 1'b0, 1'b0, 1'b0, 1'b0, WD_CLASS_UNLOCK,          2'd0, 8'h00},
    '{16'h0500, 1'b0, 1'b0, 1'b0, 1'b0, WD_CLASS_WATCHDOG_RESET,  2'd0, 8'h00},
    '{16'h0600, 1'b0, 1'b0, 1'b0, 1'b0, WD_CLASS_STABILITY_RESET, 2'd0, 8'h00},
    '{16'h0700, 1'b0, 1'b0, 1'b0, 1'b0, WD_CLASS_FUNCTION_SWAP,   2'd0, 8'h00},
    '{16'h0800, 1'b0, 1'b0, 1'b0, 1'b0, WD_CLASS_DEMAP_REF_FAULT, 2'd0, 8'h00},
    '{16'h0900, 1'b0, 1'b0, 1'b1, 1'b0, WD_NONE,                  2'd0, 8'h00}
  };

endpackage

// File: logic/reg_lookup.sv
// Purpose: map a byte address onto an entry of the attribute table
// Assumes: addresses outside the decoded range never hit
// Notes:   purely combinational
`timescale 1ns/10ps
module reg_lookup
  import regbank_pkg::*;
(
  input  wire logic [15:0]      addr,
  output logic                  hit,
  output logic [IDX_W-1:0]      idx,
  output reg_attr_type          attr
);

  always_comb
  begin
    hit  = 1'b0;
    idx  = '0;
    attr = '0;
    if (addr >= ADDR_MIN && addr <= ADDR_MAX)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (REG_TABLE[i].addr == addr)
        begin
          hit  = 1'b1;
          idx  = IDX_W'(i);
          attr = REG_TABLE[i];
        end
      end
    end
  end

endmodule

// File: logic/buffered_register_access_ctrl.sv
// Purpose: buffered/active byte register bank with write-detect side effects
// Assumes: serial port and eeprom controller present single-cycle requests
// Notes:   answers come one clock after the request; denied reads give zero
`timescale 1ns/10ps

// Summary of operation
// - decode bytes from 0x0000 to 0x1788
// - multi-byte values: LSB at lowest address
// - buffered copies move on trigger write 0x01
// - live registers take effect on write
// - lock restart class forces unlock until trigger
// - ref fault class: holdover one detector cycle
// - unlock class drives loop detector unlocked
// - watchdog class holds timer until trigger
// - stability class holds timer on a changed value; runs when locked
// - function swap class stops, restarts on trigger
// - demap ref fault only in demapping mode
// - autoclear bits cleared when action completes
// - most restrictive access condition wins
// - denied or missing address: zero, no write
// - eeprom controller exclusive while active
// - read-only: serial always, eeprom never
// - excluded registers unreachable by eeprom
module buffered_register_access_ctrl
  import regbank_pkg::*;
(
  input  wire logic                    REF_CLK,
  input  wire logic                    RST_B,
  input  wire bus_req_type             SP_REQ,
  output bus_rsp_type                  SP_RSP,
  input  wire bus_req_type             EE_REQ,
  output bus_rsp_type                  EE_RSP,
  input  wire logic                    EE_ACTIVE,
  input  wire logic [1:0]              SELECTED_REF,
  input  wire logic                    DEMAP_MODE,
  input  wire logic                    SYSTEM_CLOCK_SOURCE_LOCKED,
  input  wire logic                    PD_TICK,
  input  wire logic [NUM_REGS-1:0]     FUNC_BUSY,
  input  wire logic [NUM_REGS-1:0]     ACLR_DONE,
  input  wire logic [NUM_REGS*8-1:0]   RO_VALUES,
  output logic [NUM_REGS*8-1:0]        ACTIVE_REGS,
  output logic                         LOCK_FORCE_UNLOCK,
  output logic                         DLOOP_UNLOCK,
  output logic                         REF_FAULT,
  output logic                         HOLDOVER,
  output logic                         WDOG_HOLD,
  output logic                         STAB_HOLD,
  output logic                         STAB_RUN,
  output logic                         FUNC_STOP,
  output logic                         FUNC_START
);

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  logic               sp_hit;
  logic [IDX_W-1:0]   sp_idx;
  reg_attr_type       sp_attr;
  logic               ee_hit;
  logic [IDX_W-1:0]   ee_idx;
  reg_attr_type       ee_attr;
  // address arrives already assembled high byte first
  reg_lookup u_sp_lookup
  (
    .addr (SP_REQ.addr),
    .hit  (sp_hit),
    .idx  (sp_idx),
    .attr (sp_attr)
  );

  reg_lookup u_ee_lookup
  (
    .addr (EE_REQ.addr),
    .hit  (ee_hit),
    .idx  (ee_idx),
    .attr (ee_attr)
  );

  // --------------------------------------------------------------
  // access permission
  // --------------------------------------------------------------
  logic             sp_ok;
  logic             ee_ok;
  logic             sp_is_trig;
  logic             trig;
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0]       wr_data;
  reg_attr_type     wr_attr;

  assign sp_is_trig = (SP_REQ.addr == TRIG_ADDR);
  always_comb
  begin
    // serial locked out of regular registers while eeprom runs
    // read-only stays visible to serial at all times
    sp_ok = sp_hit && (sp_attr.ro ? !SP_REQ.wr : !EE_ACTIVE);
    // read-only never reaches the eeprom controller
    // excluded registers never reach the eeprom controller
    ee_ok = ee_hit && EE_ACTIVE && !ee_attr.ro && !ee_attr.excl;
  end

  // only one source can write in a cycle: the two write permissions exclude
  // each other through EE_ACTIVE, so no arbitration stage is needed
  always_comb
  begin
    wr_en   = 1'b0;
    wr_idx  = sp_idx;
    wr_data = SP_REQ.wdata;
    wr_attr = sp_attr;
    if (ee_ok && EE_REQ.req && EE_REQ.wr)
    begin
      wr_en   = 1'b1;
      wr_idx  = ee_idx;
      wr_data = EE_REQ.wdata;
      wr_attr = ee_attr;
    end
    else if (sp_ok && SP_REQ.req && SP_REQ.wr)
      wr_en = 1'b1;
  end

  // only the exact value 0x01 transfers
  assign trig = SP_REQ.req && SP_REQ.wr && sp_is_trig && !EE_ACTIVE
                && (SP_REQ.wdata == TRIG_GO);

  // --------------------------------------------------------------
  // buffered and active storage
  // --------------------------------------------------------------
  logic [7:0] buf_q [NUM_REGS];
  logic [7:0] act_q [NUM_REGS];
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_reg
    logic wr_hit;
    assign wr_hit = wr_en && (wr_idx == IDX_W'(g));
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
      if (!RST_B)
        buf_q[g] <= REG_TABLE[g].rst;
      else if (wr_hit)
        buf_q[g] <= wr_data;
      // cleared after action so a later trigger does not repeat it
      else if (REG_TABLE[g].aclr && ACLR_DONE[g])
        buf_q[g] <= 8'h00;
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
      if (!RST_B)
        act_q[g] <= REG_TABLE[g].rst;
      else if (wr_hit && REG_TABLE[g].live)
        act_q[g] <= wr_data;
      // all entries except read-only ones copy on the same edge
      else if (trig && !REG_TABLE[g].ro)
        act_q[g] <= buf_q[g];
      // completion clears the active bit; a copy in that cycle wins
      else if (REG_TABLE[g].aclr && ACLR_DONE[g])
        act_q[g] <= 8'h00;
    end

    // entry order is address order, so weight rises with address
    assign ACTIVE_REGS[g*8 +: 8] = act_q[g];
  end

  // --------------------------------------------------------------
  // read answers
  // --------------------------------------------------------------
  logic [7:0] sp_rd;
  logic [7:0] ee_rd;
  always_comb
  begin
    // denied, missing and write-only addresses read zero
    sp_rd = DENIED_BYTE;
    ee_rd = DENIED_BYTE;
    if (sp_ok && sp_attr.ro)
      sp_rd = RO_VALUES[sp_idx*8 +: 8];
    else if (sp_ok)
      sp_rd = buf_q[sp_idx];
    if (ee_ok)
      ee_rd = buf_q[ee_idx];
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      SP_RSP <= '0;
      EE_RSP <= '0;
    end
    else
    begin
      SP_RSP.ack    <= SP_REQ.req;
      SP_RSP.denied <= SP_REQ.req && !sp_ok && !(sp_is_trig && SP_REQ.wr && !EE_ACTIVE);
      SP_RSP.rdata  <= (SP_REQ.req && !SP_REQ.wr) ? sp_rd : DENIED_BYTE;
      EE_RSP.ack    <= EE_REQ.req;
      EE_RSP.denied <= EE_REQ.req && !ee_ok;
      EE_RSP.rdata  <= (EE_REQ.req && !EE_REQ.wr) ? ee_rd : DENIED_BYTE;
    end
  end

  // --------------------------------------------------------------
  // write-detect side effects
  // --------------------------------------------------------------
  logic cls_lock;
  logic cls_unlock;
  logic cls_fault;
  logic cls_wdog;
  logic cls_stab;
  logic cls_func;

  always_comb
  begin
    cls_lock   = wr_en && (wr_attr.wd == WD_CLASS_LOCK_RESTART);
    cls_unlock = wr_en && (wr_attr.wd == WD_CLASS_UNLOCK);
    cls_wdog   = wr_en && (wr_attr.wd == WD_CLASS_WATCHDOG_RESET);
    cls_stab   = wr_en && (wr_attr.wd == WD_CLASS_STABILITY_RESET)
                 && (wr_data != buf_q[wr_idx]);
    // only when the register feeds a running function
    cls_func   = wr_en && (wr_attr.wd == WD_CLASS_FUNCTION_SWAP) && FUNC_BUSY[wr_idx];
    cls_fault  = wr_en && (wr_attr.ref_id == SELECTED_REF)
                 && ((wr_attr.wd == WD_CLASS_REF_FAULT)
                 || (wr_attr.wd == WD_CLASS_DEMAP_REF_FAULT && DEMAP_MODE));
  end

  // unlocked from the write until the trigger; a write wins
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      LOCK_FORCE_UNLOCK <= 1'b0;
    else if (cls_lock)
      LOCK_FORCE_UNLOCK <= 1'b1;
    else if (trig)
      LOCK_FORCE_UNLOCK <= 1'b0;
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      DLOOP_UNLOCK <= 1'b0;
    else
      DLOOP_UNLOCK <= cls_unlock;
  end

  // watchdog held between write and trigger
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      WDOG_HOLD <= 1'b0;
    else if (cls_wdog)
      WDOG_HOLD <= 1'b1;
    else if (trig)
      WDOG_HOLD <= 1'b0;
  end

  // stability timer held, then counts only with a locked clock
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      STAB_HOLD <= 1'b0;
    else if (cls_stab)
      STAB_HOLD <= 1'b1;
    else if (trig)
      STAB_HOLD <= 1'b0;
  end
  assign STAB_RUN = !STAB_HOLD && SYSTEM_CLOCK_SOURCE_LOCKED;

  // stop level until trigger, then one start pulse
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      FUNC_STOP  <= 1'b0;
      FUNC_START <= 1'b0;
    end
    else
    begin
      FUNC_START <= trig && FUNC_STOP;
      if (cls_func)
        FUNC_STOP <= 1'b1;
      else if (trig)
        FUNC_STOP <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // reference fault and holdover sequencing
  // --------------------------------------------------------------
  logic               fault_pend_q;
  holdover_state_type ho_q;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      fault_pend_q <= 1'b0;
    else if (cls_fault)
      fault_pend_q <= 1'b1;
    else if (trig)
      fault_pend_q <= 1'b0;
  end

  // holdover spans whole detector periods: tick to next tick
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ho_q      <= HO_IDLE;
      REF_FAULT <= 1'b0;
    end
    else
    begin
      REF_FAULT <= trig && fault_pend_q;
      case (ho_q)
        HO_IDLE:
          if (trig && fault_pend_q)
            ho_q <= HO_ARMED;
        HO_ARMED:
          if (PD_TICK)
            ho_q <= HO_ACTIVE;
        HO_ACTIVE:
          if (PD_TICK)
            ho_q <= HO_IDLE;
        default:
          ho_q <= HO_IDLE;
      endcase
    end
  end
  assign HOLDOVER = (ho_q == HO_ACTIVE);

endmodule

// File: dv/regbank_chk.sv
// Purpose: port-level checks of the register bank
// Assumes: one clock, RST_B active low
// Notes:   bound into every instance of the bank
`timescale 1ns/10ps
module regbank_chk
  import regbank_pkg::*;
(
  input wire logic                  REF_CLK,
  input wire logic                  RST_B,
  input wire bus_req_type           SP_REQ,
  input wire bus_rsp_type           SP_RSP,
  input wire bus_req_type           EE_REQ,
  input wire bus_rsp_type           EE_RSP,
  input wire logic                  EE_ACTIVE,
  input wire logic                  SYSTEM_CLOCK_SOURCE_LOCKED,
  input wire logic                  PD_TICK,
  input wire logic [NUM_REGS*8-1:0] ACTIVE_REGS,
  input wire logic                  LOCK_FORCE_UNLOCK,
  input wire logic                  DLOOP_UNLOCK,
  input wire logic                  REF_FAULT,
  input wire logic                  HOLDOVER,
  input wire logic                  WDOG_HOLD,
  input wire logic                  STAB_HOLD,
  input wire logic                  STAB_RUN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // serial writes only land while the eeprom side is idle
  logic sp_w;
  assign sp_w = SP_REQ.req && SP_REQ.wr && !EE_ACTIVE;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  a_range_denied:
    assert property (SP_REQ.req && SP_REQ.addr > ADDR_MAX |=> SP_RSP.ack && SP_RSP.denied)
      else $error("out of range address not denied");
  a_denied_zero:
    assert property (SP_RSP.denied |-> SP_RSP.rdata == DENIED_BYTE) else $error("denied data");
  a_ee_idle_deny:
    assert property (EE_REQ.req && !EE_ACTIVE |=> EE_RSP.ack && EE_RSP.denied)
      else $error("idle eeprom access allowed");
  a_sp_shut_out:
    assert property (SP_REQ.req && EE_ACTIVE && SP_REQ.addr == 16'h0300 |=> SP_RSP.denied)
      else $error("serial reached regular register");
  a_ro_open:
    assert property (SP_REQ.req && !SP_REQ.wr && SP_REQ.addr == 16'h0003 |=> !SP_RSP.denied)
      else $error("read-only register refused");
  a_ee_excluded:
    assert property (EE_REQ.req && (EE_REQ.addr == 16'h0003 || EE_REQ.addr == 16'h0101)
      |=> EE_RSP.denied) else $error("excluded register reached");
  a_live_now:
    assert property (sp_w && SP_REQ.addr == 16'h0100
      |=> ACTIVE_REGS[15:8] == $past(SP_REQ.wdata)) else $error("live write late");
  a_lock_force:
    assert property (sp_w && SP_REQ.addr == 16'h0200 |=> LOCK_FORCE_UNLOCK)
      else $error("no forced unlock");
  a_unlock_pulse:
    assert property (sp_w && SP_REQ.addr == 16'h0400 |=> DLOOP_UNLOCK) else $error("no unlock");
  a_wdog_hold:
    assert property (sp_w && SP_REQ.addr == 16'h0500 |=> WDOG_HOLD) else $error("no hold");
  a_trig_release:
    assert property (sp_w && SP_REQ.addr == TRIG_ADDR && SP_REQ.wdata == TRIG_GO
      |=> !WDOG_HOLD && !LOCK_FORCE_UNLOCK && !STAB_HOLD) else $error("holds survive trigger");
  a_stab_run:
    assert property (STAB_RUN == (!STAB_HOLD && SYSTEM_CLOCK_SOURCE_LOCKED)) else $error("stability run");
  a_ho_start:
    assert property ($rose(HOLDOVER) |-> $past(PD_TICK)) else $error("holdover off tick");
  a_ho_end:
    assert property (HOLDOVER && PD_TICK |=> !HOLDOVER) else $error("holdover too long");

  cover property ($rose(HOLDOVER));
  cover property (EE_RSP.ack && !EE_RSP.denied);
  cover property (REF_FAULT);
endmodule

bind buffered_register_access_ctrl regbank_chk chk (.REF_CLK, .RST_B, .SP_REQ, .SP_RSP,
  .EE_REQ, .EE_RSP, .EE_ACTIVE, .SYSTEM_CLOCK_SOURCE_LOCKED, .PD_TICK, .ACTIVE_REGS, .LOCK_FORCE_UNLOCK,
  .DLOOP_UNLOCK, .REF_FAULT, .HOLDOVER, .WDOG_HOLD, .STAB_HOLD, .STAB_RUN);

// File: dv/far_side_model.sv
// Purpose: serial host and eeprom controller request side
// Assumes: one byte per call, requests change at the falling edge
// Notes:   idle buses show inverted leftovers so stale values never pass
`timescale 1ns/10ps
module far_side_model
  import regbank_pkg::*;
(
  input  wire logic REF_CLK,
  output bus_req_type SP_REQ,
  output bus_req_type EE_REQ
);
  bus_req_type r;

  initial
  begin
    SP_REQ = '0;
    EE_REQ = '0;
  end

  task automatic op(input logic ee, input logic w, input logic [15:0] a, input logic [7:0] wd);
    r = '{req: 1'b1, wr: w, addr: {a[15:8], a[7:0]}, wdata: wd};
    @(negedge REF_CLK);
    if (ee) EE_REQ = r;
    else SP_REQ = r;
    @(negedge REF_CLK);
    r = '{req: 1'b0, wr: ~w, addr: ~a, wdata: ~wd};
    if (ee) EE_REQ = r;
    else SP_REQ = r;
  endtask
endmodule

// File: dv/test_buffered_register_access_ctrl.sv
// Purpose: self-checking bench of the register bank
// Assumes: responses one clock after each request
// Notes:   response checks go through per-bus queues of expectations
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module test_buffered_register_access_ctrl
  import regbank_pkg::*;
;
  logic ref_clk, rst_b, ee_active, demap, sys_locked, pd_tick, rf_seen, fs_seen;
  logic [1:0] sel_ref;
  logic [NUM_REGS-1:0] func_busy, aclr_done;
  logic [NUM_REGS*8-1:0] ro_values, active_regs;
  bus_req_type sp_req, ee_req;
  bus_rsp_type sp_rsp, ee_rsp;
  logic lock_fu, dl_unlock, ref_fault, holdover, wdog_hold, stab_hold, stab_run, fstop, fstart;
  logic [8:0] sq[$], eq[$], e;
  logic [7:0] d;
  logic [15:0] v;
  int n_mismatch, n_compared, seed, cyc;
  localparam logic [15:0] HA [5] = '{16'h0300, 16'h0301, 16'h0800, 16'h0800, 16'h0301};

  buffered_register_access_ctrl dut (.REF_CLK(ref_clk), .RST_B(rst_b), .SP_REQ(sp_req),
    .SP_RSP(sp_rsp), .EE_REQ(ee_req), .EE_RSP(ee_rsp), .EE_ACTIVE(ee_active),
    .SELECTED_REF(sel_ref), .DEMAP_MODE(demap), .SYSTEM_CLOCK_SOURCE_LOCKED(sys_locked), .PD_TICK(pd_tick),
    .FUNC_BUSY(func_busy), .ACLR_DONE(aclr_done), .RO_VALUES(ro_values),
    .ACTIVE_REGS(active_regs), .LOCK_FORCE_UNLOCK(lock_fu), .DLOOP_UNLOCK(dl_unlock),
    .REF_FAULT(ref_fault), .HOLDOVER(holdover), .WDOG_HOLD(wdog_hold), .STAB_HOLD(stab_hold),
    .STAB_RUN(stab_run), .FUNC_STOP(fstop), .FUNC_START(fstart));
  far_side_model fm (.REF_CLK(ref_clk), .SP_REQ(sp_req), .EE_REQ(ee_req));

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic xf(input logic ee, w, input logic [15:0] a, input logic [7:0] wd,
                    input logic dn, input logic [7:0] rd);
    if (ee) eq.push_back({dn, rd});
    else sq.push_back({dn, rd});
    fm.op(ee, w, a, wd);
  endtask
  task automatic trig;
    xf(1'b0, 1'b1, TRIG_ADDR, TRIG_GO, 1'b0, 8'h00);
  endtask
  task automatic pd;
    pd_tick = 1'b1;
    tick(1);
    pd_tick = 1'b0;
  endtask
  task automatic close_out;
    // an expectation left in a queue means a response never came
    if (sq.size() != 0 || eq.size() != 0)
      n_mismatch++;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // short pulses are latched here so the main flow never races them
  always @(negedge ref_clk)
  begin
    if (ref_fault === 1'b1) rf_seen = 1'b1;
    if (fstart === 1'b1) fs_seen = 1'b1;
    if (sp_rsp.ack === 1'b1)
    begin
      e = sq.pop_front();
      `CHK({sp_rsp.denied, sp_rsp.rdata}, e)
    end
    if (ee_rsp.ack === 1'b1)
    begin
      e = eq.pop_front();
      `CHK({ee_rsp.denied, ee_rsp.rdata}, e)
    end
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      close_out;
    end
  end

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial
  begin
    seed = 21;
    {rst_b, ee_active, demap, pd_tick, sel_ref, func_busy, aclr_done} = '0;
    sys_locked = 1'b1;
    ro_values = '0;
    ro_values[7:0] = 8'($random(seed));
    tick(12);
    rst_b = 1'b1;
    `CHK(active_regs, {96'h0, 8'h05})
    xf(0, 0, 16'h0003, 8'h00, 0, ro_values[7:0]);
    xf(0, 0, TRIG_ADDR, 8'h00, 1, 8'h00);
    xf(0, 0, 16'h1789, 8'h00, 1, 8'h00);
    xf(0, 1, 16'h0002, 8'h33, 1, 8'h00);
    xf(0, 1, 16'h0003, 8'haa, 1, 8'h00);
    xf(0, 0, 16'h0003, 8'h00, 0, ro_values[7:0]);
    d = 8'($random(seed));
    xf(0, 1, 16'h0100, d, 0, 8'h00);
    `CHK(active_regs[15:8], d)
    v = 16'($random(seed));
    xf(0, 1, 16'h0200, v[7:0], 0, 8'h00);
    xf(0, 1, 16'h0201, v[15:8], 0, 8'h00);
    xf(0, 1, TRIG_ADDR, 8'h02, 0, 8'h00);
    `CHK({lock_fu, active_regs[39:24]}, 17'h10000)
    trig;
    `CHK({lock_fu, active_regs[39:24]}, {1'b0, v})
    func_busy[10] = 1'b1;
    xf(0, 1, 16'h0500, d, 0, 8'h00);
    xf(0, 1, 16'h0600, 8'h5a, 0, 8'h00);
    xf(0, 1, 16'h0700, d, 0, 8'h00);
    xf(0, 1, 16'h0400, d, 0, 8'h00);
    `CHK({wdog_hold, stab_hold, stab_run, fstop, dl_unlock}, 5'b11011)
    sys_locked = 1'b0;
    fs_seen = 1'b0;
    trig;
    tick(2);
    `CHK({wdog_hold, stab_hold, stab_run, fstop, fs_seen}, 5'b00001)
    sys_locked = 1'b1;
    xf(0, 1, 16'h0600, 8'h5a, 0, 8'h00);
    `CHK({stab_hold, stab_run}, 2'b01)
    for (int i = 0; i < 5; i++)
    begin
      demap = (i == 3);
      sel_ref = 2'(i == 4);
      xf(0, 1, HA[i], d, 0, 8'h00);
      rf_seen = 1'b0;
      trig;
      tick(1);
      `CHK(rf_seen, (i == 0 || i >= 3))
      pd;
      `CHK(holdover, (i == 0 || i >= 3))
      tick(3);
      pd;
      `CHK(holdover, 1'b0)
    end
    xf(1, 1, 16'h0300, d, 1, 8'h00);
    ee_active = 1'b1;
    xf(1, 1, 16'h0300, ~d, 0, 8'h00);
    xf(1, 0, 16'h0300, 8'h00, 0, ~d);
    xf(1, 0, 16'h0003, 8'h00, 1, 8'h00);
    xf(1, 1, 16'h0101, d, 1, 8'h00);
    xf(0, 0, 16'h0300, 8'h00, 1, 8'h00);
    xf(0, 0, 16'h0003, 8'h00, 0, ro_values[7:0]);
    ee_active = 1'b0;
    xf(0, 1, 16'h0900, d, 0, 8'h00);
    trig;
    `CHK(active_regs[103:96], d)
    aclr_done[12] = 1'b1;
    tick(1);
    aclr_done[12] = 1'b0;
    xf(0, 0, 16'h0900, 8'h00, 0, 8'h00);
    `CHK(active_regs[103:96], 8'h00)
    tick(2);
    close_out;
  end
endmodule
